// ==== hottest_slope_pkg.sv ====
// Constants shared by the hottest-channel and slope monitor
package hottest_slope_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_ONE_SHOT      = 8'h0F;
  localparam logic [7:0] ADDR_SLOPE_GAIN    = 8'h3D;
  localparam logic [7:0] ADDR_SLOPE_CONFIG  = 8'h3E;
  localparam logic [7:0] ADDR_SLOPE_STATUS  = 8'h3F;
  localparam logic [7:0] ADDR_RESULT_CH1_HI = 8'h40;
  localparam logic [7:0] ADDR_LIMIT_CH1     = 8'h41;
  localparam logic [7:0] ADDR_SAMPLES_CH1   = 8'h43;
  localparam logic [7:0] ADDR_RESULT_CH2_HI = 8'h44;
  localparam logic [7:0] ADDR_RESULT_LOW    = 8'h45;
  localparam logic [7:0] ADDR_LIMIT_CH2     = 8'h46;
  localparam logic [7:0] ADDR_SAMPLES_CH2   = 8'h48;
  localparam logic [7:0] ADDR_PERIOD_MAX    = 8'h49;
  localparam logic [7:0] ADDR_GLOBAL_MAX    = 8'h4D;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_ENABLE_BIT  = 5;   // Rate computation enable
  localparam int CFG_MASK_BIT    = 7;   // Blocks rate alerts from the pin
  localparam int CFG_HYST_LSB    = 0;   // Slope hysteresis threshold
  localparam int CFG_HYST_W      = 3;
  localparam int STAT_LIMIT_LSB  = 0;   // Limit exceeded, one bit per channel
  localparam int STAT_SLOPE_LSB  = 4;   // Slope changed, one bit per channel
  localparam int GAIN_CODE_W     = 4;   // Gain code in the low nibble
  localparam int FRAC_W          = 3;   // Fraction bits below the result LSB
  localparam int LOW_NIBBLE_CH2  = 4;   // Result low byte: channel 2 nibble

  // ----------------------------------------------------------------
  // Coding constants and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] GAIN_UNITY_CODE = 4'h8;  // Code for a gain of one
  localparam logic [7:0] SAMPLES_MIN     = 8'h01; // Code zero behaves as this
  localparam logic [7:0] RST_GAIN        = 8'h08;
  localparam logic [7:0] RST_CONFIG      = 8'h00;
  localparam logic [7:0] RST_LIMIT       = 8'h7F;
  localparam logic [7:0] RST_SAMPLES     = 8'h02;
  localparam logic [7:0] RST_TEMP        = 8'h00;
  localparam logic [7:0] READ_UNMAPPED   = 8'h00;

  // Per-channel sequencer states, Gray along idle, divide, done
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DIV  = 2'b01,
    ST_DONE = 2'b11
  } div_state_t;

endpackage

// ==== hottest_and_slope_monitor.sv ====
// Hottest-channel compare, temperature slope computation and max tracking
module hottest_and_slope_monitor
  import hottest_slope_pkg::*;
#(
  parameter int NUM_CH = 5,   // Internal diode plus four external
  parameter int TEMP_W = 8,
  parameter int NUM_W  = 20   // Divider dividend width
)(
  // Clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     reset_n,
  // Register port behind the two-wire host interface
  input  wire logic [7:0]               reg_addr,
  input  wire logic [7:0]               reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [7:0]               reg_rdata_q,
  // Conversion engine
  input  wire logic                     conv_done,
  input  wire logic [NUM_CH*TEMP_W-1:0] chan_temps,
  input  wire logic [NUM_CH-1:0]        chan_enable,
  input  wire logic [NUM_CH-1:0]        hottest_select,
  input  wire logic                     diode2_anti_parallel,
  output logic                          one_shot_start_q,
  // Hottest compare
  input  wire logic                     remember_hottest_enable,
  input  wire logic                     hottest_event_clear,
  output logic      [TEMP_W-1:0]        hottest_temp_q,
  output logic      [NUM_CH-1:0]        hottest_status_q,
  output logic                          hottest_event_q,
  // Alert pin, low when asserted
  output logic                          alert_n_q
);

  localparam int RES_W = TEMP_W + 1 + FRAC_W;  // 9-bit integer plus fraction
  localparam int REM_W = TEMP_W + 2;
  localparam int STEP_W = $clog2(NUM_W + 1);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] gain_q, config_q, status_q, status_d;
  logic [7:0] limit_q [2];
  logic [7:0] samples_q [2];
  logic [TEMP_W-1:0] period_max_q, global_max_q;
  logic [1:0] lim_evt, slope_evt;
  logic [RES_W-1:0] result [2];

  // Address decode
  wire wr_one_shot = reg_wr && (reg_addr == ADDR_ONE_SHOT);
  wire wr_gain     = reg_wr && (reg_addr == ADDR_SLOPE_GAIN);
  wire wr_config   = reg_wr && (reg_addr == ADDR_SLOPE_CONFIG);
  wire wr_lim1     = reg_wr && (reg_addr == ADDR_LIMIT_CH1);
  wire wr_lim2     = reg_wr && (reg_addr == ADDR_LIMIT_CH2);
  wire wr_smp1     = reg_wr && (reg_addr == ADDR_SAMPLES_CH1);
  wire wr_smp2     = reg_wr && (reg_addr == ADDR_SAMPLES_CH2);
  wire rd_status   = reg_rd && (reg_addr == ADDR_SLOPE_STATUS);

  wire                  rate_enable = config_q[CFG_ENABLE_BIT];
  wire                  rate_mask   = config_q[CFG_MASK_BIT];
  wire [CFG_HYST_W-1:0] hyst        = config_q[CFG_HYST_LSB +: CFG_HYST_W];

  // Gain shift: code 8 is unity, each step above doubles
  wire [GAIN_CODE_W-1:0] gain_code = gain_q[GAIN_CODE_W-1:0];
  wire [GAIN_CODE_W-1:0] gain_shift =
    (gain_code >= GAIN_UNITY_CODE) ? gain_code - GAIN_UNITY_CODE : '0;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Configuration registers
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      gain_q       <= RST_GAIN;
      config_q     <= RST_CONFIG;
      limit_q[0]   <= RST_LIMIT;
      limit_q[1]   <= RST_LIMIT;
      samples_q[0] <= RST_SAMPLES;
      samples_q[1] <= RST_SAMPLES;
    end
    else
    begin
      if (wr_gain)   gain_q       <= reg_wdata;
      if (wr_config) config_q     <= reg_wdata;
      if (wr_lim1)   limit_q[0]   <= reg_wdata;
      if (wr_lim2)   limit_q[1]   <= reg_wdata;
      if (wr_smp1)   samples_q[0] <= reg_wdata;
      if (wr_smp2)   samples_q[1] <= reg_wdata;
    end
  end

  // One-shot request to the conversion engine, one cycle wide
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      one_shot_start_q <= 1'b0;
    else
      one_shot_start_q <= wr_one_shot;
  end

  // ----------------------------------------------------------------
  // Hottest-of comparison
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0] hot_sel, hot_ties;
  logic [TEMP_W-1:0] hot_max;

  // Maximum over enabled and selected channels, then every tie
  always_comb
  begin
    hot_sel = chan_enable & hottest_select;
    hot_max = '0;
    for (int i = 0; i < NUM_CH; i++)
      if (hot_sel[i] && chan_temps[i*TEMP_W +: TEMP_W] > hot_max)
        hot_max = chan_temps[i*TEMP_W +: TEMP_W];
    hot_ties = '0;
    for (int i = 0; i < NUM_CH; i++)
      hot_ties[i] = hot_sel[i] && (chan_temps[i*TEMP_W +: TEMP_W] == hot_max);
  end

  wire hot_update = conv_done && (|hot_sel);
  wire hot_change = hot_update && remember_hottest_enable &&
                    (|hottest_status_q) && (hot_ties != hottest_status_q);

  // Hottest result, status and change event (set wins over clear)
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hottest_temp_q   <= RST_TEMP;
      hottest_status_q <= '0;
      hottest_event_q  <= 1'b0;
    end
    else
    begin
      if (hot_update)
      begin
        hottest_temp_q   <= hot_max;
        hottest_status_q <= hot_ties;
      end
      if (hot_change)
        hottest_event_q <= 1'b1;
      else if (hottest_event_clear)
        hottest_event_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Slope channels
  // ----------------------------------------------------------------
  // Channel 0 watches diode one; channel 1 diode two, or three behind a pair
  wire [1:0] rate_src_en;
  wire [TEMP_W-1:0] rate_temp [2];
  assign rate_temp[0] = chan_temps[1*TEMP_W +: TEMP_W];
  assign rate_temp[1] = diode2_anti_parallel ? chan_temps[3*TEMP_W +: TEMP_W]
                                             : chan_temps[2*TEMP_W +: TEMP_W];
  assign rate_src_en[0] = chan_enable[1];
  assign rate_src_en[1] = diode2_anti_parallel ? chan_enable[3] : chan_enable[2];

  logic [1:0] first_smp;
  logic [1:0] last_smp;

  for (genvar c = 0; c < 2; c++)
  begin : g_rate
    div_state_t        state_q;
    logic [7:0]        count_q;
    logic [TEMP_W-1:0] start_q, prev_q;
    logic              dir_up_q, dir_valid_q;
    logic [NUM_W-1:0]  quot_q;
    logic [REM_W-1:0]  rem_q;
    logic [REM_W-1:0]  div_q;
    logic [STEP_W-1:0] step_q;
    logic              neg_q;
    logic [RES_W-1:0]  res_q;

    // Sample count n = 2*code+1, so the divisor n-1 is 2*code
    wire [7:0]  code_eff = (samples_q[c] == '0) ? SAMPLES_MIN : samples_q[c];
    wire [8:0]  last_idx = {code_eff, 1'b0};
    wire        sample   = conv_done && rate_enable && rate_src_en[c];
    wire [TEMP_W-1:0] t  = rate_temp[c];
    wire        is_first = (count_q == '0);
    wire        is_last  = ({1'b0, count_q} == last_idx);

    // Magnitude and sign of final minus start, scaled by gain and fraction
    wire [TEMP_W:0]   delta  = {1'b0, t} - {1'b0, start_q};
    wire              d_neg  = delta[TEMP_W];
    wire [TEMP_W:0]   d_mag  = d_neg ? (~delta + 1'b1) : delta;
    wire [NUM_W-1:0]  d_ext  = {{(NUM_W-TEMP_W-1){1'b0}}, d_mag};
    wire [NUM_W-1:0]  numer  = d_ext << (gain_shift + FRAC_W);

    // Step direction versus hysteresis
    wire              rising = t > prev_q;
    wire [TEMP_W-1:0] step_mag = rising ? t - prev_q : prev_q - t;
    wire              big_step = (step_mag > {{(TEMP_W-CFG_HYST_W){1'b0}}, hyst});
    wire              reversal = dir_valid_q && (t != prev_q) && (rising != dir_up_q);

    // Restoring divider step
    wire [REM_W-1:0]  rem_sh = {rem_q[REM_W-2:0], quot_q[NUM_W-1]};
    wire              take   = rem_sh >= div_q;

    // Saturate quotient to the signed result width
    wire              ovf    = |quot_q[NUM_W-1:RES_W-1];
    wire [RES_W-1:0]  mag    = ovf ? {1'b0, {(RES_W-1){1'b1}}} : quot_q[RES_W-1:0];
    wire [RES_W-1:0]  signed_res = neg_q ? (~mag + 1'b1) : mag;

    // Signed limit: high byte holds result bits above the shared LSB
    wire [RES_W-1:0]  lim_full = {limit_q[c], {(FRAC_W+1){1'b0}}};
    wire              exceeds  = limit_q[c][7] ? ($signed(signed_res) < $signed(lim_full))
                                               : ($signed(signed_res) > $signed(lim_full));

    assign first_smp[c] = sample && is_first;
    assign last_smp[c]  = sample && is_last;
    assign slope_evt[c] = sample && !is_first && reversal && big_step;
    assign lim_evt[c]   = (state_q == ST_DONE) && exceeds;
    assign result[c]    = res_q;

    // Sample bookkeeping and initial direction
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        count_q     <= '0;
        start_q     <= RST_TEMP;
        prev_q      <= RST_TEMP;
        dir_up_q    <= 1'b0;
        dir_valid_q <= 1'b0;
      end
      else if (!rate_enable)
      begin
        count_q     <= '0;
        dir_valid_q <= 1'b0;
      end
      else if (sample)
      begin
        prev_q  <= t;
        count_q <= is_last ? '0 : count_q + 8'h01;
        if (is_first)
        begin
          start_q     <= t;
          dir_valid_q <= 1'b0;
        end
        else if (!dir_valid_q && t != prev_q)
        begin
          dir_up_q    <= rising;
          dir_valid_q <= 1'b1;
        end
        else if (reversal && big_step)
          dir_up_q <= rising;
      end
    end

    // Division sequencer, started by the last sample of the period
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        state_q <= ST_IDLE;
        quot_q  <= '0;
        rem_q   <= '0;
        div_q   <= '0;
        step_q  <= '0;
        neg_q   <= 1'b0;
        res_q   <= '0;
      end
      else
      begin
        case (state_q)
          ST_IDLE:
            if (last_smp[c])
            begin
              quot_q  <= numer;
              rem_q   <= '0;
              div_q   <= {1'b0, last_idx};
              neg_q   <= d_neg;
              step_q  <= '0;
              state_q <= ST_DIV;
            end
          ST_DIV:
          begin
            rem_q  <= take ? rem_sh - div_q : rem_sh;
            quot_q <= {quot_q[NUM_W-2:0], take};
            step_q <= step_q + 1'b1;
            if (step_q == STEP_W'(NUM_W - 1))
              state_q <= ST_DONE;
          end
          ST_DONE:
          begin
            res_q   <= signed_res;
            state_q <= ST_IDLE;
          end
          default:
            state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Slope status, period and global maximum
  // ----------------------------------------------------------------
  // Status sets always; read clears, a same-cycle set survives
  always_comb
  begin
    status_d = rd_status ? '0 : status_q;
    status_d[STAT_LIMIT_LSB +: 2] = status_d[STAT_LIMIT_LSB +: 2] | lim_evt;
    status_d[STAT_SLOPE_LSB +: 2] = status_d[STAT_SLOPE_LSB +: 2] | slope_evt;
  end

  wire [TEMP_W-1:0] t0 = rate_temp[0];
  wire [TEMP_W-1:0] pmax_next =
    (first_smp[0] || t0 > period_max_q) ? t0 : period_max_q;

  // Status and maximum history
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      status_q     <= '0;
      period_max_q <= RST_TEMP;
      global_max_q <= RST_TEMP;
    end
    else
    begin
      status_q <= status_d;
      if (conv_done && rate_enable && rate_src_en[0])
        period_max_q <= pmax_next;
      if (last_smp[0] && pmax_next > global_max_q)
        global_max_q <= pmax_next;
    end
  end

  // ----------------------------------------------------------------
  // Alert pin and read data
  // ----------------------------------------------------------------
  // Limit status bits pass the mask before reaching the pin; slope bits never reach it
  wire rate_alert = (|status_q[STAT_LIMIT_LSB +: 2]) && !rate_mask;

  // Result low byte: each nibble is the shared LSB then three fraction bits
  wire [7:0] result_low = {result[1][FRAC_W:0], result[0][FRAC_W:0]};

  logic [7:0] rd_mux;
  always_comb
  begin
    case (reg_addr)
      ADDR_SLOPE_GAIN:    rd_mux = gain_q;
      ADDR_SLOPE_CONFIG:  rd_mux = config_q;
      ADDR_SLOPE_STATUS:  rd_mux = status_q;
      ADDR_RESULT_CH1_HI: rd_mux = result[0][RES_W-1 -: 8];
      ADDR_LIMIT_CH1:     rd_mux = limit_q[0];
      ADDR_SAMPLES_CH1:   rd_mux = samples_q[0];
      ADDR_RESULT_CH2_HI: rd_mux = result[1][RES_W-1 -: 8];
      ADDR_RESULT_LOW:    rd_mux = result_low;
      ADDR_LIMIT_CH2:     rd_mux = limit_q[1];
      ADDR_SAMPLES_CH2:   rd_mux = samples_q[1];
      ADDR_PERIOD_MAX:    rd_mux = period_max_q;
      ADDR_GLOBAL_MAX:    rd_mux = global_max_q;
      default:            rd_mux = READ_UNMAPPED;
    endcase
  end

  // Registered read data and alert pin
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reg_rdata_q <= READ_UNMAPPED;
      alert_n_q   <= 1'b1;
    end
    else
    begin
      if (reg_rd)
        reg_rdata_q <= rd_mux;
      alert_n_q <= !(hottest_event_q || rate_alert);
    end
  end

endmodule

// ==== hottest_monitor_sva.sv ====
// Concurrent checks on the hottest compare and one-shot outputs
module hottest_monitor_sva
  import hottest_slope_pkg::*;
#(
  parameter int NUM_CH = 5,
  parameter int TEMP_W = 8
)(
  // Clock, reset and register port
  input wire logic                     ref_clk,
  input wire logic                     reset_n,
  input wire logic [7:0]               reg_addr,
  input wire logic                     reg_wr,
  input wire logic                     one_shot_start_q,
  // Conversion input and hottest outputs
  input wire logic                     conv_done,
  input wire logic [NUM_CH*TEMP_W-1:0] chan_temps,
  input wire logic [NUM_CH-1:0]        chan_enable,
  input wire logic [NUM_CH-1:0]        hottest_select,
  input wire logic                     remember_hottest_enable,
  input wire logic                     hottest_event_clear,
  input wire logic [TEMP_W-1:0]        hottest_temp_q,
  input wire logic [NUM_CH-1:0]        hottest_status_q,
  input wire logic                     hottest_event_q,
  input wire logic                     alert_n_q
);
  logic [TEMP_W-1:0] top_w;
  logic [NUM_CH-1:0] pick_w;
  logic [NUM_CH-1:0] tie_w;

  default clocking dflt_cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  // Reference maximum and tie set over selected, enabled channels
  assign pick_w = hottest_select & chan_enable;
  always_comb
  begin
    top_w = '0;
    tie_w = '0;
    for (int i = 0; i < NUM_CH; i++)
      if (pick_w[i] && chan_temps[i*TEMP_W +: TEMP_W] > top_w)
        top_w = chan_temps[i*TEMP_W +: TEMP_W];
    for (int i = 0; i < NUM_CH; i++)
      tie_w[i] = pick_w[i] && (chan_temps[i*TEMP_W +: TEMP_W] == top_w);
  end

  oneshot_pulse_a: assert property (reg_wr && reg_addr == ADDR_ONE_SHOT |=> one_shot_start_q)
    else $error("one-shot write gave no start pulse");
  oneshot_cause_a: assert property (one_shot_start_q |-> $past(reg_wr) && $past(reg_addr) == ADDR_ONE_SHOT)
    else $error("start pulse without one-shot write");
  hottest_hold_a: assert property (!conv_done |=> $stable(hottest_temp_q) && $stable(hottest_status_q))
    else $error("hottest outputs moved between conversions");
  hottest_value_a: assert property (conv_done && |pick_w |=> hottest_temp_q == $past(top_w))
    else $error("hottest value is not the selected maximum");
  tie_status_a: assert property (conv_done && |pick_w |=> hottest_status_q == $past(tie_w))
    else $error("hottest status does not flag exactly the tied channels");
  no_pick_a: assert property (conv_done && !(|pick_w) |=> $stable(hottest_temp_q))
    else $error("hottest value changed with no channel selected");
  event_alert_a: assert property ($rose(hottest_event_q) |-> ##[1:2] !alert_n_q)
    else $error("hottest change did not drive the alert pin");
  event_cause_a: assert property ($rose(hottest_event_q) |-> $past(conv_done) && $past(remember_hottest_enable))
    else $error("hottest event without conversion or remember option");
  event_clear_a: assert property (hottest_event_clear && !conv_done |=> !hottest_event_q)
    else $error("hottest event not cleared");
endmodule

bind hottest_and_slope_monitor hottest_monitor_sva #(.NUM_CH(NUM_CH), .TEMP_W(TEMP_W))
  hottest_monitor_sva_inst (
  .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .one_shot_start_q(one_shot_start_q), .conv_done(conv_done), .chan_temps(chan_temps),
  .chan_enable(chan_enable), .hottest_select(hottest_select),
  .remember_hottest_enable(remember_hottest_enable), .hottest_event_clear(hottest_event_clear),
  .hottest_temp_q(hottest_temp_q), .hottest_status_q(hottest_status_q),
  .hottest_event_q(hottest_event_q), .alert_n_q(alert_n_q));

// ==== conv_engine_model.sv ====
// Conversion engine partner: one conversion for each one-shot start taken while idle
module conv_engine_model (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // Trigger, sample to report and conversion time
  input  wire logic        start,
  input  wire logic [39:0] temps_in,
  input  wire logic [7:0]  lag,
  // Result towards the monitor
  output logic             conv_done,
  output logic      [39:0] chan_temps
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  count_q;
  logic        busy_q;
  logic [39:0] held_q;

  // Count out the conversion time, then report one sample
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count_q   <= 8'h00;
      busy_q    <= 1'b0;
      held_q    <= 40'h00;
      conv_done <= 1'b0;
    end
    else
    begin
      conv_done <= 1'b0;
      if (start && !busy_q)
      begin
        busy_q  <= 1'b1;
        count_q <= lag;
      end
      else if (busy_q && count_q == 8'h00)
      begin
        busy_q    <= 1'b0;
        conv_done <= 1'b1;
        held_q    <= temps_in;
      end
      else if (busy_q)
        count_q <= count_q - 8'h01;
    end
  end

  // Outside the done cycle the bus carries no valid sample
  assign chan_temps = conv_done ? held_q : ~held_q;
endmodule

// ==== test_hottest_and_slope_monitor.sv ====
// Self-checking bench for the hottest and slope monitor
module test_hottest_and_slope_monitor import hottest_slope_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        diode2_anti_parallel = 1'b0, remember_hottest_enable = 1'b0;
  logic        hottest_event_clear = 1'b0, conv_done, one_shot_start_q;
  logic        hottest_event_q, alert_n_q;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, lag_v = 8'h01;
  logic [7:0]  reg_rdata_q, hottest_temp_q;
  logic [4:0]  chan_enable = 5'h1F, hottest_select = 5'h1A, hottest_status_q;
  logic [39:0] chan_temps, temps_v = 40'h00;
  int          err_total = 0, comparisons = 0;
  logic [15:0] rst_tab [13] = '{16'h3D08, 16'h3E00, 16'h3F00, 16'h4000, 16'h417F, 16'h4302,
                                16'h4400, 16'h4500, 16'h467F, 16'h4802, 16'h4900, 16'h4D00,
                                16'h5000};
  logic [15:0] set_tab [6]  = '{16'h3D09, 16'h4302, 16'h4802, 16'h4101, 16'h4601, 16'h3E20};
  logic [15:0] mask_tab [5] = '{16'h4007, 16'h4407, 16'h4588, 16'h4928, 16'h4D28};
  logic [15:0] fin_tab [5]  = '{16'h4002, 16'h4402, 16'h4588, 16'h492D, 16'h4D2D};
  logic [7:0]  seq [5]      = '{8'h19, 8'h23, 8'h1E, 8'h2D, 8'h23};
  logic [7:0]  stat [5]     = '{8'h00, 8'h00, 8'h30, 8'h30, 8'h33};

  // Device under test and conversion partner
  hottest_and_slope_monitor hottest_and_slope_monitor_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .conv_done(conv_done),
    .chan_temps(chan_temps), .chan_enable(chan_enable), .hottest_select(hottest_select),
    .diode2_anti_parallel(diode2_anti_parallel), .one_shot_start_q(one_shot_start_q),
    .remember_hottest_enable(remember_hottest_enable),
    .hottest_event_clear(hottest_event_clear), .hottest_temp_q(hottest_temp_q),
    .hottest_status_q(hottest_status_q), .hottest_event_q(hottest_event_q),
    .alert_n_q(alert_n_q));
  conv_engine_model conv_engine_model_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .start(one_shot_start_q), .temps_in(temps_v),
    .lag(lag_v), .conv_done(conv_done), .chan_temps(chan_temps));

  // 200 MHz reference clock
  always #2.5 ref_clk = ~ref_clk;

  // Counts, verdict and end of run
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Register port cycles: one-cycle strobes, read data one cycle later
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic read_check(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    check(what, reg_rdata_q, exp);
  endtask

  task automatic read_list(input logic [15:0] tab [5]);
    for (int i = 0; i < 5; i++)
      read_check("slope readout", tab[i][15:8], tab[i][7:0]);
  endtask

  function automatic logic [39:0] pack(input logic [7:0] c1, input logic [7:0] c2,
                                       input logic [7:0] c3, input logic [7:0] c4);
    return {c4, c3, c2, c1, 8'h00};
  endfunction

  // One-shot conversion, bounded wait for the sample, then settle time
  task automatic convert(input logic [39:0] t);
    int n;
    n = 0;
    temps_v <= t;
    reg_write(ADDR_ONE_SHOT, 8'hFF);
    while (conv_done !== 1'b1 && n < 100)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n == 100)
    begin
      err_total++;
      wrap_up();
    end
    repeat (30) @(posedge ref_clk);
    #1;
  endtask

  // Main sequence
  initial
  begin
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 13; i++)
      read_check("reset value", rst_tab[i][15:8], rst_tab[i][7:0]);
    reg_write(ADDR_RESULT_CH1_HI, 8'h55);
    read_check("read-only result", ADDR_RESULT_CH1_HI, 8'h00);
    convert(pack(8'h10, 8'h63, 8'h28, 8'h1E));
    check("hottest temp", hottest_temp_q, 8'h28);
    check("hottest status", {3'b000, hottest_status_q}, 8'h08);
    lag_v <= 8'h0A;
    convert(pack(8'h10, 8'h63, 8'h3C, 8'h3C));
    check("tie status", {3'b000, hottest_status_q}, 8'h18);
    check("event off", {7'h00, hottest_event_q}, 8'h00);
    @(posedge ref_clk);
    remember_hottest_enable <= 1'b1;
    convert(pack(8'h10, 8'h63, 8'h3C, 8'h46));
    check("new hottest", {3'b000, hottest_status_q}, 8'h10);
    check("hottest event", {7'h00, hottest_event_q}, 8'h01);
    check("alert pin", {7'h00, alert_n_q}, 8'h00);
    @(posedge ref_clk);
    hottest_select <= 5'h00;
    convert(pack(8'h10, 8'h7F, 8'h7F, 8'h7F));
    check("no selection", hottest_temp_q, 8'h46);
    @(posedge ref_clk);
    hottest_event_clear     <= 1'b1;
    remember_hottest_enable <= 1'b0;
    hottest_select          <= 5'h1A;
    @(posedge ref_clk);
    hottest_event_clear <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    check("event cleared", {7'h00, hottest_event_q}, 8'h00);
    check("alert released", {7'h00, alert_n_q}, 8'h01);
    reg_write(8'h03, 8'h40);
    read_check("standby place", 8'h03, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      reg_write(set_tab[i][15:8], set_tab[i][7:0]);
      read_check("setup", set_tab[i][15:8], set_tab[i][7:0]);
    end
    reg_write(ADDR_SAMPLES_CH1, 8'h01);
    reg_write(ADDR_SAMPLES_CH2, 8'h01);
    reg_write(ADDR_SLOPE_CONFIG, 8'hA0);
    convert(pack(8'h19, 8'h19, 8'h00, 8'h00));
    convert(pack(8'h23, 8'h23, 8'h00, 8'h00));
    read_check("mid period", ADDR_SLOPE_STATUS, 8'h00);
    convert(pack(8'h28, 8'h28, 8'h00, 8'h00));
    check("masked alert", {7'h00, alert_n_q}, 8'h01);
    read_check("masked status", ADDR_SLOPE_STATUS, 8'h03);
    read_list(mask_tab);
    reg_write(ADDR_SAMPLES_CH1, 8'h02);
    reg_write(ADDR_SAMPLES_CH2, 8'h02);
    reg_write(ADDR_SLOPE_CONFIG, 8'h20);
    @(posedge ref_clk);
    diode2_anti_parallel <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      convert(pack(seq[i], 8'h14, seq[i], 8'h00));
      if (i == 4)
        check("limit alert", {7'h00, alert_n_q}, 8'h00);
      read_check("slope status", ADDR_SLOPE_STATUS, stat[i]);
      if (i == 3)
      begin
        read_check("period max mid", ADDR_PERIOD_MAX, 8'h2D);
        read_check("global max held", ADDR_GLOBAL_MAX, 8'h28);
      end
    end
    read_list(fin_tab);
    @(posedge ref_clk);
    chan_enable <= 5'h1D;
    convert(pack(8'h50, 8'h14, 8'h50, 8'h00));
    check("disabled hottest", {3'b000, hottest_status_q}, 8'h08);
    read_check("disabled source", ADDR_PERIOD_MAX, 8'h2D);
    wrap_up();
  end
endmodule
